// >>> src/sfs_consts.svh
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

// Clock period of core_clk in nanoseconds.
`define SFS_CLK_NS 8

// Filter times in nanoseconds.
`define SFS_T_BAT_UV_NS 10000
`define SFS_T_LOGIC_UV_NS 2000
`define SFS_T_OVERVOLT_NS 5000
`define SFS_T_OVERTEMP_NS 20000
`define SFS_T_SHORT0_NS 1000
`define SFS_T_SHORT1_NS 2000
`define SFS_T_SHORT2_NS 3000
`define SFS_T_SHORT3_NS 6000

// Least times round up to whole clock cycles.
`define SFS_CYC(ns) (((ns) + `SFS_CLK_NS - 1) / `SFS_CLK_NS)
`define SFS_BAT_UV_CYC `SFS_CYC(`SFS_T_BAT_UV_NS)
`define SFS_LOGIC_UV_CYC `SFS_CYC(`SFS_T_LOGIC_UV_NS)
`define SFS_OVERVOLT_CYC `SFS_CYC(`SFS_T_OVERVOLT_NS)
`define SFS_OVERTEMP_CYC `SFS_CYC(`SFS_T_OVERTEMP_NS)
`define SFS_SHORT0_CYC `SFS_CYC(`SFS_T_SHORT0_NS)
`define SFS_SHORT1_CYC `SFS_CYC(`SFS_T_SHORT1_NS)
`define SFS_SHORT2_CYC `SFS_CYC(`SFS_T_SHORT2_NS)
`define SFS_SHORT3_CYC `SFS_CYC(`SFS_T_SHORT3_NS)

// Mode codes.
`define SFS_BAT_DIAG_NONE 2'h0
`define SFS_BAT_DIAG_FOLLOW 2'h1
`define SFS_MODE2_CONT 2'h0
`define SFS_MODE2_HOLD 2'h3
`define SFS_SC_CONT 3'h0
`define SFS_SC_PHASE_OFF 3'h1
`define SFS_SC_PHASE_HOLD 3'h2
`define SFS_SC_ALL_OFF 3'h3
`define SFS_SC_ALL_HOLD 3'h4
`define SFS_SC_CP_OFF 3'h5
`define SFS_SC_CP_HOLD 3'h6
`define SFS_SC_NONE 3'h7

`endif

// >>> src/sfs_pkg.sv
package sfs_pkg;

   typedef enum logic [2:0] {
      ST_RUN, ST_UV_OFF, ST_LOGIC_TEST, ST_ANALOGUE_TEST, ST_TEST_FAIL,
      ST_STANDBY
   } sfs_state_e;

   typedef struct packed {
      logic [2:0] above_low_ref;
      logic [2:0] below_high_ref;
      logic [2:0] low_drive;
      logic [2:0] high_drive;
   } sfs_short_in_s;

   typedef struct packed {
      logic logic_done;
      logic logic_pass;
      logic analogue_done;
      logic analogue_pass;
   } sfs_test_in_s;

   typedef struct packed {
      logic [1:0] battery_uv_diag_mode;
      logic [1:0] overvolt_response_mode;
      logic [1:0] overtemp_response_mode;
      logic [2:0] short_response_mode;
      logic [1:0] short_threshold_sel;
      logic [1:0] short_time_sel;
   } sfs_mode_s;

   typedef struct packed {
      logic battery_uv;
      logic overvolt;
      logic overtemp;
      logic short_fault;
   } sfs_clear_s;

   typedef struct packed {
      logic [2:0] predrv_enable;
      logic       charge_pump_enable;
      logic       oscillator_enable;
      logic       power_good;
      logic       standby;
   } sfs_drive_s;

   typedef struct packed {
      logic       battery_uv;
      logic       overvolt;
      logic [2:0] overtemp;
      logic [5:0] short_flags;
   } sfs_flags_s;

endpackage

// >>> src/sfs_filter.sv
`timescale 1ns/100ps
`default_nettype none
// Counts while the comparator input stays high; any low restarts it.
module sfs_filter (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        raw,
   input  wire logic [11:0] limit,
   output logic             det
);

   logic [11:0] count;

   // Output rises after limit high cycles, falls with the first low.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         count <= 12'h000;
         det   <= 1'b0;
      end else if (!raw) begin
         count <= 12'h000;
         det   <= 1'b0;
      end else if (count >= limit - 12'h001) begin
         det <= 1'b1;
      end else begin
         count <= count + 12'h001;
      end
   end

endmodule
`default_nettype wire

// >>> src/sfs_fault_chan.sv
`timescale 1ns/100ps
`default_nettype none
// Sticky fault flags with a response mode that only changes while idle.
module sfs_fault_chan #(
   parameter int N = 1,
   parameter int W = 2
) (
   input  wire logic         core_clk,
   input  wire logic         reset,
   input  wire logic [N-1:0] active,
   input  wire logic         clear,
   input  wire logic         auto_clear,
   input  wire logic [W-1:0] mode_req,
   output logic [N-1:0]      flag,
   output logic [W-1:0]      mode_eff
);

   // Each flag sets while its fault is present; a clear then drops it.
   for (genvar i = 0; i < N; i++) begin : g_flag
      always_ff @(posedge core_clk) begin
         if (reset) begin
            flag[i] <= 1'b0;
         end else if (active[i]) begin
            flag[i] <= 1'b1;
         end else if (clear || auto_clear) begin
            flag[i] <= 1'b0;
         end
      end
   end

   // A requested mode is adopted only with no fault and no flag left.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mode_eff <= '0;
      end else if (active == '0 && flag == '0) begin
         mode_eff <= mode_req;
      end
   end

endmodule
`default_nettype wire

// >>> src/sfs_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfs_consts.svh"
// Contract
// - Battery undervoltage turns pre-drivers off; oscillator and pump run.
// - Pre-drivers stay off while battery undervoltage lasts, then resume.
// - Three selectable indicator behaviours after battery undervoltage.
// - Mode changes wait until fault gone and its flag cleared.
// - Held-low indicator after battery undervoltage returns high on clear.
// - A clear while the fault persists does nothing.
// - Logic undervoltage when either redundant comparator reports it.
// - Logic undervoltage: power-good and indicator low, all circuits off.
// - After release run logic then analogue test; pass restarts, fail stays.
// - Deeper logic undervoltage enters standby with everything off.
// - After its filter time overvoltage drives the indicator low.
// - Four overvoltage response modes in a two-bit field.
// - Overvoltage end: mode 11 holds off; other modes resume, indicator low.
// - Clearing the overvoltage flag resumes all circuits, indicator high.
// - Over-temperature when any of three filtered comparators is high.
// - Temperature signals rise after filter time, fall on release.
// - Over-temperature end: 11 holds off; indicator low until clear.
// - Eight short-circuit response modes in a three-bit field.
// - Host picks one of four short thresholds and four times.
// - Short end: 010, 100, 110 hold off; indicator low until clear.
// - High-side short: node above low reference while low drive high.
// - Low-side short: node below high reference while high drive high.
// - Hold modes stay off until clear; plain off modes recover.
module sfs_supervisor (
   input  wire logic                   core_clk,
   input  wire logic                   reset,
   input  wire logic                   battery_uv_det_a,
   input  wire logic                   battery_uv_det_b,
   input  wire logic                   logic_uv_det_a,
   input  wire logic                   logic_uv_det_b,
   input  wire logic                   logic_uv_deep,
   input  wire logic                   overvolt_cmp,
   input  wire logic [2:0]             overtemp_cmp,
   input  wire sfs_pkg::sfs_short_in_s short_in,
   input  wire sfs_pkg::sfs_test_in_s  test_in,
   input  wire sfs_pkg::sfs_mode_s     mode_in,
   input  wire sfs_pkg::sfs_clear_s    clear_in,
   output var sfs_pkg::sfs_drive_s     drive,
   output var sfs_pkg::sfs_flags_s     flags,
   output logic                        fault_indicator_n,
   output logic                        logic_self_test_start,
   output logic                        analogue_self_test_start,
   output logic [1:0]                  short_threshold_code
);
   import sfs_pkg::*;

   logic [1:0]  bat_det;
   logic        bat_uv;
   logic        uv_det;
   logic        ov_det;
   logic [2:0]  ot_det;
   logic [5:0]  sc_raw;
   logic [5:0]  sc_det;
   logic [11:0] sc_limit;
   logic        bat_flag;
   logic [1:0]  bat_mode;
   logic        ov_flag;
   logic [1:0]  ov_mode;
   logic [2:0]  ot_flag;
   logic [1:0]  ot_mode;
   logic [5:0]  sc_flag;
   logic [2:0]  sc_mode;
   logic        sc_enabled;
   sfs_state_e  state;
   sfs_state_e  next_state;

   // Two battery filters; either one declares the undervoltage.
   for (genvar i = 0; i < 2; i++) begin : g_bat
      sfs_filter u_filt (
         .core_clk (core_clk),
         .reset    (reset),
         .raw      (i == 0 ? battery_uv_det_a : battery_uv_det_b),
         .limit    (12'(`SFS_BAT_UV_CYC)),
         .det      (bat_det[i])
      );
   end
   assign bat_uv = |bat_det;

   // The redundant logic-supply comparators are combined before filtering.
   sfs_filter u_uv_filt (
      .core_clk (core_clk),
      .reset    (reset),
      .raw      (logic_uv_det_a | logic_uv_det_b),
      .limit    (12'(`SFS_LOGIC_UV_CYC)),
      .det      (uv_det)
   );

   // Overvoltage filter.
   sfs_filter u_ov_filt (
      .core_clk (core_clk),
      .reset    (reset),
      .raw      (overvolt_cmp),
      .limit    (12'(`SFS_OVERVOLT_CYC)),
      .det      (ov_det)
   );

   // Three temperature filters, each released by its own comparator.
   for (genvar i = 0; i < 3; i++) begin : g_ot
      sfs_filter u_filt (
         .core_clk (core_clk),
         .reset    (reset),
         .raw      (overtemp_cmp[i]),
         .limit    (12'(`SFS_OVERTEMP_CYC)),
         .det      (ot_det[i])
      );
   end

   // Short conditions: bits 0-2 high-side, bits 3-5 low-side, per phase.
   assign sc_raw[2:0] = short_in.above_low_ref & short_in.low_drive;
   assign sc_raw[5:3] = short_in.below_high_ref & short_in.high_drive;

   // The selected detection time sets the limit of the short filters.
   always_comb begin
      case (mode_in.short_time_sel)
         2'h0:    sc_limit = 12'(`SFS_SHORT0_CYC);
         2'h1:    sc_limit = 12'(`SFS_SHORT1_CYC);
         2'h2:    sc_limit = 12'(`SFS_SHORT2_CYC);
         default: sc_limit = 12'(`SFS_SHORT3_CYC);
      endcase
   end

   for (genvar i = 0; i < 6; i++) begin : g_sc
      sfs_filter u_filt (
         .core_clk (core_clk),
         .reset    (reset),
         .raw      (sc_raw[i]),
         .limit    (sc_limit),
         .det      (sc_det[i])
      );
   end

   // The battery flag clears itself on release unless the mode holds it.
   sfs_fault_chan #(.N(1), .W(2)) u_bat_chan (
      .core_clk   (core_clk),
      .reset      (reset),
      .active     (bat_uv),
      .clear      (clear_in.battery_uv),
      .auto_clear (bat_mode <= `SFS_BAT_DIAG_FOLLOW),
      .mode_req   (mode_in.battery_uv_diag_mode),
      .flag       (bat_flag),
      .mode_eff   (bat_mode)
   );

   sfs_fault_chan #(.N(1), .W(2)) u_ov_chan (
      .core_clk   (core_clk),
      .reset      (reset),
      .active     (ov_det),
      .clear      (clear_in.overvolt),
      .auto_clear (1'b0),
      .mode_req   (mode_in.overvolt_response_mode),
      .flag       (ov_flag),
      .mode_eff   (ov_mode)
   );

   sfs_fault_chan #(.N(3), .W(2)) u_ot_chan (
      .core_clk   (core_clk),
      .reset      (reset),
      .active     (ot_det),
      .clear      (clear_in.overtemp),
      .auto_clear (1'b0),
      .mode_req   (mode_in.overtemp_response_mode),
      .flag       (ot_flag),
      .mode_eff   (ot_mode)
   );

   // Code 111 switches short detection off entirely.
   assign sc_enabled = sc_mode != `SFS_SC_NONE;

   sfs_fault_chan #(.N(6), .W(3)) u_sc_chan (
      .core_clk   (core_clk),
      .reset      (reset),
      .active     (sc_det & {6{sc_enabled}}),
      .clear      (clear_in.short_fault),
      .auto_clear (1'b0),
      .mode_req   (mode_in.short_response_mode),
      .flag       (sc_flag),
      .mode_eff   (sc_mode)
   );

   // Supply sequencer: undervoltage off, self-test restart, standby.
   always_comb begin
      next_state = state;
      case (state)
         ST_RUN, ST_TEST_FAIL: begin
            if (uv_det) begin
               next_state = ST_UV_OFF;
            end
         end
         ST_UV_OFF: begin
            if (!uv_det) begin
               next_state = ST_LOGIC_TEST;
            end
         end
         ST_LOGIC_TEST: begin
            if (uv_det) begin
               next_state = ST_UV_OFF;
            end else if (test_in.logic_done) begin
               next_state = test_in.logic_pass ? ST_ANALOGUE_TEST
                                               : ST_TEST_FAIL;
            end
         end
         ST_ANALOGUE_TEST: begin
            if (uv_det) begin
               next_state = ST_UV_OFF;
            end else if (test_in.analogue_done) begin
               next_state = test_in.analogue_pass ? ST_RUN
                                                  : ST_TEST_FAIL;
            end
         end
         ST_STANDBY: begin
            if (!logic_uv_deep) begin
               next_state = ST_UV_OFF;
            end
         end
         default: next_state = ST_UV_OFF;
      endcase
      if (logic_uv_deep) begin
         next_state = ST_STANDBY;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Each self test is started by a one-cycle pulse on entry.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         logic_self_test_start    <= 1'b0;
         analogue_self_test_start <= 1'b0;
      end else begin
         logic_self_test_start <= next_state == ST_LOGIC_TEST &&
                                  state != ST_LOGIC_TEST;
         analogue_self_test_start <= next_state == ST_ANALOGUE_TEST &&
                                     state != ST_ANALOGUE_TEST;
      end
   end

   logic       ov_on;
   logic       ot_on;
   logic       sc_hold;
   logic [2:0] sc_phase_on;
   logic [2:0] sc_pd_off;
   logic       sc_cp_off;
   logic       pd_all_off;
   logic       cp_off;
   logic       supply_up;
   logic       diag_low;

   // Shutdown terms of each fault in its current response mode.
   always_comb begin
      ov_on = ov_det ||
              (ov_flag && ov_mode == `SFS_MODE2_HOLD);
      ot_on = (|ot_det) ||
              ((|ot_flag) && ot_mode == `SFS_MODE2_HOLD);
      sc_hold = sc_mode == `SFS_SC_PHASE_HOLD ||
                sc_mode == `SFS_SC_ALL_HOLD ||
                sc_mode == `SFS_SC_CP_HOLD;
      sc_phase_on = (sc_det[2:0] | sc_det[5:3]) |
                    ({3{sc_hold}} & (sc_flag[2:0] | sc_flag[5:3]));
      sc_pd_off = 3'h0;
      sc_cp_off = 1'b0;
      case (sc_mode)
         `SFS_SC_PHASE_OFF, `SFS_SC_PHASE_HOLD: sc_pd_off = sc_phase_on;
         `SFS_SC_ALL_OFF, `SFS_SC_ALL_HOLD: sc_pd_off = {3{|sc_phase_on}};
         `SFS_SC_CP_OFF, `SFS_SC_CP_HOLD: begin
            sc_pd_off = {3{|sc_phase_on}};
            sc_cp_off = |sc_phase_on;
         end
         default: sc_pd_off = 3'h0;
      endcase
      pd_all_off = bat_uv ||
                   (ov_on && ov_mode != `SFS_MODE2_CONT) ||
                   (ot_on && ot_mode != `SFS_MODE2_CONT);
      cp_off = sc_cp_off || (ov_on && ov_mode[1]) ||
               (ot_on && ot_mode[1]);
      supply_up = state != ST_UV_OFF && state != ST_STANDBY;
      diag_low = state != ST_RUN || ov_flag || (|ot_flag) ||
                 (|sc_flag) ||
                 (bat_flag && bat_mode != `SFS_BAT_DIAG_NONE);
   end

   // Registered drive outputs; only the run state lets pre-drivers and charge pump work.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         drive             <= '0;
         fault_indicator_n <= 1'b1;
      end else begin
         drive.predrv_enable <= {3{state == ST_RUN && !pd_all_off}} &
                                ~sc_pd_off;
         drive.charge_pump_enable <= state == ST_RUN && !cp_off;
         drive.oscillator_enable  <= supply_up;
         drive.power_good         <= supply_up;
         drive.standby            <= state == ST_STANDBY;
         fault_indicator_n        <= !diag_low;
      end
   end

   // Flag and threshold outputs are registered copies.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         flags                <= '0;
         short_threshold_code <= 2'h0;
      end else begin
         flags.battery_uv     <= bat_flag;
         flags.overvolt       <= ov_flag;
         flags.overtemp       <= ot_flag;
         flags.short_flags    <= sc_flag;
         short_threshold_code <= mode_in.short_threshold_sel;
      end
   end

endmodule
`default_nettype wire

// >>> test/sfs_supervisor_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfs_consts.svh"
// Watches the supervisor ports for the fault responses.
module sfs_supervisor_assertions (
   input wire logic                   core_clk,
   input wire logic                   reset,
   input wire logic                   battery_uv_det_a,
   input wire logic                   battery_uv_det_b,
   input wire logic                   logic_uv_det_a,
   input wire logic                   logic_uv_det_b,
   input wire logic                   logic_uv_deep,
   input wire logic                   overvolt_cmp,
   input wire logic [2:0]             overtemp_cmp,
   input wire sfs_pkg::sfs_short_in_s short_in,
   input wire sfs_pkg::sfs_clear_s    clear_in,
   input wire sfs_pkg::sfs_drive_s    drive,
   input wire sfs_pkg::sfs_flags_s    flags,
   input wire logic                   fault_indicator_n,
   input wire logic                   logic_self_test_start,
   input wire logic                   analogue_self_test_start
);
   import sfs_pkg::*;
   localparam int BN = `SFS_BAT_UV_CYC;
   localparam int LN = `SFS_LOGIC_UV_CYC;
   localparam int ON = `SFS_OVERVOLT_CYC;
   localparam int TN = `SFS_OVERTEMP_CYC;
   logic [11:0] bat_cnt, luv_cnt, ov_cnt, ot_cnt;

   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   // Saturating run length, so a long fault never wraps back to zero.
   function automatic logic [11:0] step(input logic [11:0] c, input logic on);
      return on && !reset ? c + 12'(c != 12'hFFF) : 12'h0;
   endfunction

   // Counts consecutive high samples of each raw comparator group.
   always_ff @(posedge core_clk) begin
      bat_cnt <= step(bat_cnt, battery_uv_det_a || battery_uv_det_b);
      luv_cnt <= step(luv_cnt, logic_uv_det_a || logic_uv_det_b);
      ov_cnt <= step(ov_cnt, overvolt_cmp);
      ot_cnt <= step(ot_cnt, |overtemp_cmp);
   end

   chk_bat_predrv_off: assert property (
      bat_cnt > BN + 2 && drive.power_good |-> drive.predrv_enable == 3'h0
      && drive.charge_pump_enable && drive.oscillator_enable)
      else $error("battery undervoltage drive wrong");
   chk_logic_uv_off: assert property (
      luv_cnt > LN + 2 |-> drive == 7'h00 && !fault_indicator_n)
      else $error("logic undervoltage drive wrong");
   chk_ov_indicator: assert property (
      ov_cnt > ON + 2 |-> !fault_indicator_n && flags.overvolt)
      else $error("overvoltage not shown on indicator");
   chk_ot_filter_time: assert property (
      $rose(|flags.overtemp) |-> $past(ot_cnt) >= TN - 2)
      else $error("overtemp flagged too early");
   chk_short_hs_cause: assert property (
      $rose(flags.short_flags[1]) |->
      $past(short_in.above_low_ref[1] && short_in.low_drive[1], 2))
      else $error("high-side short without cause");
   chk_short_ls_cause: assert property (
      $rose(flags.short_flags[5]) |->
      $past(short_in.below_high_ref[2] && short_in.high_drive[2], 2))
      else $error("low-side short without cause");
   chk_standby_all_off: assert property (
      logic_uv_deep [*4] |-> drive == 7'h01)
      else $error("standby drive word wrong");
   chk_test_after_uv: assert property (
      $rose(drive.power_good) && !$past(reset, 2) |->
      $past(logic_self_test_start))
      else $error("restart without logic self-test");
   chk_clear_ignored: assert property (
      flags.overvolt && ov_cnt > ON + 2 && clear_in.overvolt |=>
      flags.overvolt)
      else $error("overvoltage flag cleared in fault");

   cov_standby: cover property (drive.standby);
   cov_overvolt: cover property ($rose(flags.overvolt));
   cov_tests: cover property (
      logic_self_test_start ##[1:20] analogue_self_test_start);
endmodule
`default_nettype wire

// >>> test/sfs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host side self-test responder; the bench chooses pass or fail.
module sfs_host_model (
   input wire logic              core_clk,
   input wire logic              reset,
   input wire logic              logic_self_test_start,
   input wire logic              analogue_self_test_start,
   input wire logic              pass,
   output var sfs_pkg::sfs_test_in_s test_in
);
   import sfs_pkg::*;
   logic [2:0] lwait, await_cnt;

   // Each test pulses done for one cycle, four cycles after its start.
   // A done that stayed high would end the next test before it began.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         test_in <= '0;
         lwait <= 3'h0;
         await_cnt <= 3'h0;
      end else begin
         lwait <= logic_self_test_start ? 3'h3 : lwait - 3'(lwait != 3'h0);
         await_cnt <= analogue_self_test_start ? 3'h3
                      : await_cnt - 3'(await_cnt != 3'h0);
         test_in <= {lwait == 3'h1, pass, await_cnt == 3'h1, pass};
      end
   end
endmodule
`default_nettype wire

// >>> test/tb_supply_temp_short_fault_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
$display("wrong value %s exp %0h got %0h", n, e, g); end end
// Self-checking bench for the fault supervisor.
module tb_supply_temp_short_fault_supervisor;
   import sfs_pkg::*;
   logic          core_clk = 1'b0;
   logic          reset = 1'b1;
   logic          battery_uv_det_a = 1'b0, battery_uv_det_b = 1'b0;
   logic          logic_uv_det_a = 1'b0, logic_uv_det_b = 1'b0;
   logic          logic_uv_deep = 1'b0, overvolt_cmp = 1'b0, pass = 1'b1;
   logic [2:0]    overtemp_cmp = 3'h0;
   sfs_short_in_s short_in = '0;
   sfs_mode_s     mode_in = '0;
   sfs_clear_s    clear_in = '0;
   sfs_test_in_s  test_in;
   sfs_drive_s    drive, ed;
   sfs_flags_s    flags;
   logic          fault_indicator_n, lst, ast;
   logic [1:0]    short_threshold_code;
   logic [2:0]    pd;
   int            fails = 0, cmp_count = 0;
   int            m, t, n;
   int unsigned   seed = 59;

   sfs_supervisor sfs_supervisor_i (.core_clk(core_clk), .reset(reset),
      .battery_uv_det_a(battery_uv_det_a), .battery_uv_det_b(battery_uv_det_b),
      .logic_uv_det_a(logic_uv_det_a), .logic_uv_det_b(logic_uv_det_b),
      .logic_uv_deep(logic_uv_deep), .overvolt_cmp(overvolt_cmp),
      .overtemp_cmp(overtemp_cmp), .short_in(short_in), .test_in(test_in),
      .mode_in(mode_in), .clear_in(clear_in), .drive(drive), .flags(flags),
      .fault_indicator_n(fault_indicator_n), .logic_self_test_start(lst),
      .analogue_self_test_start(ast),
      .short_threshold_code(short_threshold_code));
   sfs_host_model sfs_host_model_i (.core_clk(core_clk), .reset(reset),
      .logic_self_test_start(lst), .analogue_self_test_start(ast),
      .pass(pass), .test_in(test_in));

   // Free-running 125 MHz clock.
   always #4 core_clk = ~core_clk;

   // Inputs move one nanosecond after the rising edge.
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   // Xorshift source with a fixed start.
   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Drive word with oscillator and power-good on.
   function automatic sfs_drive_s run_d(input logic [2:0] p, input logic c);
      return {p, c, 3'b110};
   endfunction

   // Host clears one flag group only once its fault has ended.
   task automatic clr(input int k);
      clear_in = 4'(1 << k);
      cyc(1);
      clear_in = '0;
      cyc(5);
   endtask

   task automatic tally_and_finish();
      if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Bounded wait for the run state after a supply restart.
   task automatic wait_run();
      int i;
      for (i = 0; i < 300 && drive !== run_d(3'h7, 1'b1); i++) cyc(1);
      if (i == 300) begin
         fails++;
         tally_and_finish();
      end
   endtask

   // Overvoltage (k=2) or over-temperature (k=1) in all four modes.
   task automatic chan(input int k);
      for (int j = 0; j < 4; j++) begin
         if (k == 2) mode_in.overvolt_response_mode = 2'(j);
         else mode_in.overtemp_response_mode = 2'(j);
         cyc(2);
         if (k == 2) overvolt_cmp = 1'b1;
         else overtemp_cmp = 3'(1 << (rnd() % 3));
         clear_in = 4'(1 << k);
         cyc(k == 2 ? 640 : 2515);
         `CHK("fault drive", run_d(j ? 3'h0 : 3'h7, j < 2), drive)
         `CHK("indicator", 1'b0, fault_indicator_n)
         `CHK("flag", 1'b1, k == 2 ? flags.overvolt : |flags.overtemp)
         clear_in = '0;
         if (k == 2) mode_in.overvolt_response_mode = 2'(rnd());
         else mode_in.overtemp_response_mode = 2'(rnd());
         overvolt_cmp = 1'b0;
         overtemp_cmp = 3'h0;
         cyc(6);
         ed = j == 3 ? run_d(3'h0, 1'b0) : run_d(3'h7, 1'b1);
         `CHK("end drive", ed, drive)
         `CHK("end indicator", 1'b0, fault_indicator_n)
         clr(k);
         `CHK("cleared drive", run_d(3'h7, 1'b1), drive)
         `CHK("cleared indicator", 1'b1, fault_indicator_n)
      end
   endtask

   // Main sequence: battery, overvoltage, temperature, short, logic supply.
   initial begin
      cyc(4);
      reset = 1'b0;
      cyc(2);
      for (m = 0; m < 3; m++) begin
         mode_in.battery_uv_diag_mode = 2'(m);
         cyc(2);
         battery_uv_det_a = m[0];
         battery_uv_det_b = !m[0];
         cyc(1265);
         `CHK("bat drive", run_d(3'h0, 1'b1), drive)
         `CHK("bat indicator", m == 0, fault_indicator_n)
         mode_in.battery_uv_diag_mode = 2'(rnd());
         battery_uv_det_a = 1'b0;
         battery_uv_det_b = 1'b0;
         cyc(6);
         `CHK("bat end drive", run_d(3'h7, 1'b1), drive)
         `CHK("bat end indicator", m < 2, fault_indicator_n)
         `CHK("bat end flag", m == 2, flags.battery_uv)
         clr(3);
         `CHK("bat cleared indicator", 1'b1, fault_indicator_n)
      end
      chan(2);
      chan(1);
      for (m = 0; m < 8; m++) begin
         t = rnd() % 4;
         n = t == 3 ? 750 : 125 * (t + 1);
         mode_in.short_response_mode = 3'(m);
         mode_in.short_time_sel = 2'(t);
         mode_in.short_threshold_sel = 2'(rnd());
         cyc(2);
         `CHK("code", mode_in.short_threshold_sel, short_threshold_code)
         pd = m[0] ? 3'h3 : 3'h5;
         // Odd modes: low-side short on C; even: high-side short on B.
         short_in = m[0] ? 12'h104 : 12'h410;
         cyc(n - 3);
         short_in = '0;
         cyc(3);
         `CHK("short glitch", 6'h00, flags.short_flags)
         short_in = m[0] ? 12'h104 : 12'h410;
         cyc(n + 12);
         `CHK("short flags", m == 7 ? 6'h00 : m[0] ? 6'h20 : 6'h02,
              flags.short_flags)
         ed = m == 0 || m == 7 ? run_d(3'h7, 1'b1) : m < 3 ? run_d(pd, 1'b1)
              : m < 5 ? run_d(3'h0, 1'b1) : run_d(3'h0, 1'b0);
         `CHK("short drive", ed, drive)
         `CHK("short indicator", m == 7, fault_indicator_n)
         short_in = '0;
         cyc(6);
         if (m != 2 && m != 4 && m != 6) ed = run_d(3'h7, 1'b1);
         `CHK("short end drive", ed, drive)
         `CHK("short end indicator", m == 7, fault_indicator_n)
         clr(0);
         `CHK("short cleared", run_d(3'h7, 1'b1), drive)
         `CHK("short cleared ind", 1'b1, fault_indicator_n)
      end
      logic_uv_det_b = 1'b1;
      cyc(262);
      `CHK("uv drive", 7'h00, drive)
      `CHK("uv indicator", 1'b0, fault_indicator_n)
      logic_uv_det_b = 1'b0;
      wait_run();
      `CHK("uv restart ind", 1'b1, fault_indicator_n)
      pass = 1'b0;
      logic_uv_det_a = 1'b1;
      cyc(262);
      logic_uv_det_a = 1'b0;
      cyc(40);
      `CHK("fail drive", 4'h0,
           {drive.predrv_enable, drive.charge_pump_enable})
      `CHK("fail indicator", 1'b0, fault_indicator_n)
      logic_uv_deep = 1'b1;
      cyc(5);
      `CHK("standby drive", 7'h01, drive)
      pass = 1'b1;
      logic_uv_deep = 1'b0;
      wait_run();
      `CHK("standby exit ind", 1'b1, fault_indicator_n)
      tally_and_finish();
   end
endmodule

bind sfs_supervisor sfs_supervisor_assertions sfs_supervisor_assertions_i (
   .core_clk(core_clk), .reset(reset), .battery_uv_det_a(battery_uv_det_a),
   .battery_uv_det_b(battery_uv_det_b), .logic_uv_det_a(logic_uv_det_a),
   .logic_uv_det_b(logic_uv_det_b), .logic_uv_deep(logic_uv_deep),
   .overvolt_cmp(overvolt_cmp), .overtemp_cmp(overtemp_cmp),
   .short_in(short_in), .clear_in(clear_in), .drive(drive), .flags(flags),
   .fault_indicator_n(fault_indicator_n),
   .logic_self_test_start(logic_self_test_start),
   .analogue_self_test_start(analogue_self_test_start));
`default_nettype wire
